// [shared/rsi_pkg.sv]
// Overview of operation
// - lin1 power-good event sets bit 6, W1C
// - lin0 power-good event sets bit 2, W1C
// - lin1 short over 1 ms sets bit 5
// - lin0 short over 1 ms sets bit 1
// - lin1 current limit sets bit 4, W1C
// - lin0 current limit sets bit 0, W1C
// - flag bits 7 and 3 stay zero
// - top status bit 7 shows power-good pin
// - top status bit 4 shows clock invalid
// - top status bit 3 shows thermal shutdown
// - top status bit 2 shows thermal warning
// - top status bit 1 shows input overvoltage
// - buck status bits 7,3 show converter enables
// - buck status bits 6,2 show output invalid
// - buck status bits 4,0 show current limit
// - status bits read-only, reset zero, unlatched
// - pending summary clears when flags all zero
package rsi_pkg;
	// register offsets
	localparam logic [7:0] LIN_FLAGS_ADDR = 8'h1c;
	localparam logic [7:0] TOP_STAT_ADDR  = 8'h1d;
	localparam logic [7:0] BUCK_STAT_ADDR = 8'h1e;
	localparam logic [7:0] REG_RESET_VAL  = 8'h00;

	// linear regulator flag bit positions
	localparam int LIN0_CURLIM_BIT = 0;
	localparam int LIN0_SHORT_BIT  = 1;
	localparam int LIN0_PWRGD_BIT  = 2;
	localparam int LIN1_CURLIM_BIT = 4;
	localparam int LIN1_SHORT_BIT  = 5;
	localparam int LIN1_PWRGD_BIT  = 6;
	localparam logic [7:0] LIN_FLAGS_MASK = 8'h77;

	// top status bit positions
	localparam int TOP_OVP_BIT   = 1;
	localparam int TOP_TWARN_BIT = 2;
	localparam int TOP_TSD_BIT   = 3;
	localparam int TOP_CLKINV_BIT = 4;
	localparam int TOP_PGPIN_BIT = 7;

	// buck status bit positions
	localparam int CONV0_CURLIM_BIT = 0;
	localparam int CONV0_INVAL_BIT  = 2;
	localparam int CONV0_EN_BIT     = 3;
	localparam int CONV1_CURLIM_BIT = 4;
	localparam int CONV1_INVAL_BIT  = 6;
	localparam int CONV1_EN_BIT     = 7;

	// index of each raw condition in the synchroniser vector
	localparam int IX_LIN1_PGF  = 0;
	localparam int IX_LIN0_PGF  = 1;
	localparam int IX_LIN1_SC   = 2;
	localparam int IX_LIN0_SC   = 3;
	localparam int IX_LIN1_ILIM = 4;
	localparam int IX_LIN0_ILIM = 5;
	localparam int IX_PGPIN     = 6;
	localparam int IX_CLKINV    = 7;
	localparam int IX_TSD       = 8;
	localparam int IX_TWARN     = 9;
	localparam int IX_OVP       = 10;
	localparam int IX_C1_EN     = 11;
	localparam int IX_C0_EN     = 12;
	localparam int IX_C1_INV    = 13;
	localparam int IX_C0_INV    = 14;
	localparam int IX_C1_ILIM   = 15;
	localparam int IX_C0_ILIM   = 16;
	localparam int NUM_RAW      = 17;

	// short-circuit filter time
	localparam int SC_TIME_US   = 1000;
	localparam int CLK_MHZ      = 40;
	localparam int SC_CYCLES    = SC_TIME_US * CLK_MHZ;
	localparam int SC_CNT_W     = 16;
endpackage : rsi_pkg

// [shared/rsi_sc_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface rsi_sc_if;
	logic below;
	logic expired;
	modport timer (input below, output expired);
	modport ctrl (output below, input expired);
endinterface : rsi_sc_if
`default_nettype wire

// [verilog/rsi_short_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module rsi_short_timer #(
	parameter int unsigned CYCLES = rsi_pkg::SC_CYCLES
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// filter channel
	rsi_sc_if.timer  sc
);
	localparam logic [rsi_pkg::SC_CNT_W-1:0] LAST = rsi_pkg::SC_CNT_W'(CYCLES);

	logic [rsi_pkg::SC_CNT_W-1:0] cnt_r;
	logic                         expired_r;

	// saturating count of consecutive cycles below threshold
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_r <= '0;
		end else if (!sc.below) begin
			cnt_r <= '0;
		end else if (cnt_r != LAST) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// one pulse per continuous short, not a level, so a cleared flag stays clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			expired_r <= 1'b0;
		end else begin
			expired_r <= sc.below && (cnt_r == LAST - 1'b1);
		end
	end

	assign sc.expired = expired_r;

	expire_count_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		expired_r |-> (cnt_r == LAST))
		else $error("short pulse without full count");

	short_restart_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		!sc.below |=> (cnt_r == '0) && !expired_r)
		else $error("short filter did not restart");
endmodule : rsi_short_timer
`default_nettype wire

// [verilog/rsi_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module rsi_regs #(
	parameter int unsigned SC_CYCLES = rsi_pkg::SC_CYCLES
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// register access from serial interface
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr_en,
	input  wire logic [7:0] reg_wr_data,
	input  wire logic       reg_rd_en,
	output logic      [7:0] reg_rd_data,
	// linear regulator monitors
	input  wire logic       lin1_pg_fault,
	input  wire logic       lin0_pg_fault,
	input  wire logic       lin1_below_sc,
	input  wire logic       lin0_below_sc,
	input  wire logic       lin1_curlimit,
	input  wire logic       lin0_curlimit,
	// device level monitors
	input  wire logic       power_good_pin,
	input  wire logic       ext_clock_invalid,
	input  wire logic       thermal_shutdown_cmp,
	input  wire logic       thermal_warning_cmp,
	input  wire logic       input_overvoltage_cmp,
	// buck converter monitors
	input  wire logic       conv1_enabled,
	input  wire logic       conv0_enabled,
	input  wire logic       conv1_output_invalid,
	input  wire logic       conv0_output_invalid,
	input  wire logic       conv1_curlimit,
	input  wire logic       conv0_curlimit,
	// summary to top interrupt register
	output logic            linear_pending_summary
);
	localparam int N = rsi_pkg::NUM_RAW;

	logic [N-1:0] raw_vec;
	logic [N-1:0] s1_r;
	logic [N-1:0] s2_r;
	logic [N-1:0] s3_r;
	logic [N-1:0] filt_r;
	logic         pg1_prev_r;
	logic         pg0_prev_r;
	logic [7:0]   flags_r;
	logic [7:0]   flags_nxt;
	logic [7:0]   set_vec;
	logic [7:0]   clr_vec;
	logic [7:0]   top_stat;
	logic [7:0]   buck_stat;
	logic [7:0]   rd_data_r;
	logic         summary_r;

	rsi_sc_if sc1_if ();
	rsi_sc_if sc0_if ();

	// w1c write decode, used only by the flag clear logic
	function automatic logic [7:0] w1c_clear(input logic [7:0] addr, input logic wr,
		input logic [7:0] data);
		if (wr && addr == rsi_pkg::LIN_FLAGS_ADDR) begin
			return data & rsi_pkg::LIN_FLAGS_MASK;
		end
		return 8'h00;
	endfunction : w1c_clear

	assign raw_vec[rsi_pkg::IX_LIN1_PGF]  = lin1_pg_fault;
	assign raw_vec[rsi_pkg::IX_LIN0_PGF]  = lin0_pg_fault;
	assign raw_vec[rsi_pkg::IX_LIN1_SC]   = lin1_below_sc;
	assign raw_vec[rsi_pkg::IX_LIN0_SC]   = lin0_below_sc;
	assign raw_vec[rsi_pkg::IX_LIN1_ILIM] = lin1_curlimit;
	assign raw_vec[rsi_pkg::IX_LIN0_ILIM] = lin0_curlimit;
	assign raw_vec[rsi_pkg::IX_PGPIN]     = power_good_pin;
	assign raw_vec[rsi_pkg::IX_CLKINV]    = ext_clock_invalid;
	assign raw_vec[rsi_pkg::IX_TSD]       = thermal_shutdown_cmp;
	assign raw_vec[rsi_pkg::IX_TWARN]     = thermal_warning_cmp;
	assign raw_vec[rsi_pkg::IX_OVP]       = input_overvoltage_cmp;
	assign raw_vec[rsi_pkg::IX_C1_EN]     = conv1_enabled;
	assign raw_vec[rsi_pkg::IX_C0_EN]     = conv0_enabled;
	assign raw_vec[rsi_pkg::IX_C1_INV]    = conv1_output_invalid;
	assign raw_vec[rsi_pkg::IX_C0_INV]    = conv0_output_invalid;
	assign raw_vec[rsi_pkg::IX_C1_ILIM]   = conv1_curlimit;
	assign raw_vec[rsi_pkg::IX_C0_ILIM]   = conv0_curlimit;

	// analog comparators are asynchronous; a change is taken once stages 2 and 3 agree
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1_r   <= '0;
			s2_r   <= '0;
			s3_r   <= '0;
			filt_r <= '0;
		end else begin
			s1_r <= raw_vec;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < N; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					filt_r[i] <= s3_r[i];
				end
			end
		end
	end

	// short-circuit filters, one per linear regulator
	assign sc1_if.below = filt_r[rsi_pkg::IX_LIN1_SC];
	assign sc0_if.below = filt_r[rsi_pkg::IX_LIN0_SC];

	rsi_short_timer #(.CYCLES(SC_CYCLES)) u_sc1 (
		.clk_sys (clk_sys),
		.rst     (rst),
		.sc      (sc1_if.timer)
	);

	rsi_short_timer #(.CYCLES(SC_CYCLES)) u_sc0 (
		.clk_sys (clk_sys),
		.rst     (rst),
		.sc      (sc0_if.timer)
	);

	// previous power-good fault level for event edge detect
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pg1_prev_r <= 1'b0;
			pg0_prev_r <= 1'b0;
		end else begin
			pg1_prev_r <= filt_r[rsi_pkg::IX_LIN1_PGF];
			pg0_prev_r <= filt_r[rsi_pkg::IX_LIN0_PGF];
		end
	end

	always_comb begin
		set_vec = 8'h00;
		set_vec[rsi_pkg::LIN1_PWRGD_BIT]  = filt_r[rsi_pkg::IX_LIN1_PGF] && !pg1_prev_r;
		set_vec[rsi_pkg::LIN0_PWRGD_BIT]  = filt_r[rsi_pkg::IX_LIN0_PGF] && !pg0_prev_r;
		set_vec[rsi_pkg::LIN1_SHORT_BIT]  = sc1_if.expired;
		set_vec[rsi_pkg::LIN0_SHORT_BIT]  = sc0_if.expired;
		set_vec[rsi_pkg::LIN1_CURLIM_BIT] = filt_r[rsi_pkg::IX_LIN1_ILIM];
		set_vec[rsi_pkg::LIN0_CURLIM_BIT] = filt_r[rsi_pkg::IX_LIN0_ILIM];
		clr_vec = w1c_clear(reg_addr, reg_wr_en, reg_wr_data);
		// set wins over a same-cycle clear so no event is lost
		flags_nxt = ((flags_r & ~clr_vec) | set_vec) & rsi_pkg::LIN_FLAGS_MASK;
	end

	// latched flags; reads do not touch them
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flags_r <= rsi_pkg::REG_RESET_VAL;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// summary tracks the flag register with the same timing
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			summary_r <= 1'b0;
		end else begin
			summary_r <= |flags_nxt;
		end
	end

	always_comb begin
		top_stat = 8'h00;
		top_stat[rsi_pkg::TOP_PGPIN_BIT]  = filt_r[rsi_pkg::IX_PGPIN];
		top_stat[rsi_pkg::TOP_CLKINV_BIT] = filt_r[rsi_pkg::IX_CLKINV];
		top_stat[rsi_pkg::TOP_TSD_BIT]    = filt_r[rsi_pkg::IX_TSD];
		top_stat[rsi_pkg::TOP_TWARN_BIT]  = filt_r[rsi_pkg::IX_TWARN];
		top_stat[rsi_pkg::TOP_OVP_BIT]    = filt_r[rsi_pkg::IX_OVP];
		buck_stat = 8'h00;
		buck_stat[rsi_pkg::CONV1_EN_BIT]     = filt_r[rsi_pkg::IX_C1_EN];
		buck_stat[rsi_pkg::CONV0_EN_BIT]     = filt_r[rsi_pkg::IX_C0_EN];
		buck_stat[rsi_pkg::CONV1_INVAL_BIT]  = filt_r[rsi_pkg::IX_C1_INV];
		buck_stat[rsi_pkg::CONV0_INVAL_BIT]  = filt_r[rsi_pkg::IX_C0_INV];
		buck_stat[rsi_pkg::CONV1_CURLIM_BIT] = filt_r[rsi_pkg::IX_C1_ILIM];
		buck_stat[rsi_pkg::CONV0_CURLIM_BIT] = filt_r[rsi_pkg::IX_C0_ILIM];
	end

	// read data holds until the next read; unmapped offsets read zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_data_r <= rsi_pkg::REG_RESET_VAL;
		end else if (reg_rd_en) begin
			unique case (reg_addr)
				rsi_pkg::LIN_FLAGS_ADDR: rd_data_r <= flags_r;
				rsi_pkg::TOP_STAT_ADDR:  rd_data_r <= top_stat;
				rsi_pkg::BUCK_STAT_ADDR: rd_data_r <= buck_stat;
				default:                 rd_data_r <= 8'h00;
			endcase
		end
	end

	assign reg_rd_data            = rd_data_r;
	assign linear_pending_summary = summary_r;

	default clocking dflt_cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	pg1_event_a: assert property (
		(filt_r[rsi_pkg::IX_LIN1_PGF] && !pg1_prev_r) |=> flags_r[rsi_pkg::LIN1_PWRGD_BIT])
		else $error("lin1 power-good event not latched");

	pg0_event_a: assert property (
		(filt_r[rsi_pkg::IX_LIN0_PGF] && !pg0_prev_r) |=> flags_r[rsi_pkg::LIN0_PWRGD_BIT])
		else $error("lin0 power-good event not latched");

	short1_latch_a: assert property (
		sc1_if.expired |=> flags_r[rsi_pkg::LIN1_SHORT_BIT] && summary_r)
		else $error("lin1 short not latched");

	short0_latch_a: assert property (
		sc0_if.expired |=> flags_r[rsi_pkg::LIN0_SHORT_BIT])
		else $error("lin0 short not latched");

	curlim1_latch_a: assert property (
		filt_r[rsi_pkg::IX_LIN1_ILIM] |=> flags_r[rsi_pkg::LIN1_CURLIM_BIT])
		else $error("lin1 current limit not latched");

	curlim0_latch_a: assert property (
		filt_r[rsi_pkg::IX_LIN0_ILIM] |=> flags_r[rsi_pkg::LIN0_CURLIM_BIT])
		else $error("lin0 current limit not latched");

	reserved_zero_a: assert property (
		(reg_rd_en && reg_addr == rsi_pkg::LIN_FLAGS_ADDR) |=> !rd_data_r[7] && !rd_data_r[3])
		else $error("reserved flag bit reads one");

	pgpin_status_a: assert property (
		(reg_rd_en && reg_addr == rsi_pkg::TOP_STAT_ADDR)
		|=> rd_data_r[7] == $past(filt_r[rsi_pkg::IX_PGPIN]) && rd_data_r[0] == 1'b0)
		else $error("power-good pin status wrong");

	buck_status_a: assert property (
		(reg_rd_en && reg_addr == rsi_pkg::BUCK_STAT_ADDR)
		|=> rd_data_r[7] == $past(filt_r[rsi_pkg::IX_C1_EN])
		&& rd_data_r[4] == $past(filt_r[rsi_pkg::IX_C1_ILIM]) && !rd_data_r[5])
		else $error("buck status read wrong");

	summary_track_a: assert property (
		summary_r == (flags_r != 8'h00))
		else $error("pending summary out of step with flags");

	zero_write_keeps_a: assert property (
		(flags_r[rsi_pkg::LIN1_PWRGD_BIT] && reg_wr_en && reg_addr == rsi_pkg::LIN_FLAGS_ADDR
		&& !reg_wr_data[rsi_pkg::LIN1_PWRGD_BIT]) |=> flags_r[rsi_pkg::LIN1_PWRGD_BIT])
		else $error("zero write cleared a flag");

	read_no_effect_a: assert property (
		(reg_rd_en && !reg_wr_en) |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
		else $error("read cleared a flag");

	clkinv_status_a: assert property (
		(reg_rd_en && reg_addr == rsi_pkg::TOP_STAT_ADDR)
		|=> rd_data_r[4] == $past(filt_r[rsi_pkg::IX_CLKINV]))
		else $error("clock status read wrong");

	tsd_status_a: assert property (
		(reg_rd_en && reg_addr == rsi_pkg::TOP_STAT_ADDR)
		|=> rd_data_r[3] == $past(filt_r[rsi_pkg::IX_TSD]))
		else $error("thermal shutdown status read wrong");

	twarn_status_a: assert property (
		(reg_rd_en && reg_addr == rsi_pkg::TOP_STAT_ADDR)
		|=> rd_data_r[2] == $past(filt_r[rsi_pkg::IX_TWARN]))
		else $error("thermal warning status read wrong");

	ovp_status_a: assert property (
		(reg_rd_en && reg_addr == rsi_pkg::TOP_STAT_ADDR)
		|=> rd_data_r[1] == $past(filt_r[rsi_pkg::IX_OVP]) && !rd_data_r[6] && !rd_data_r[5])
		else $error("overvoltage status read wrong");

	conv0_en_status_a: assert property (
		(reg_rd_en && reg_addr == rsi_pkg::BUCK_STAT_ADDR)
		|=> rd_data_r[3] == $past(filt_r[rsi_pkg::IX_C0_EN]))
		else $error("buck0 enable status read wrong");

	inval_status_a: assert property (
		(reg_rd_en && reg_addr == rsi_pkg::BUCK_STAT_ADDR)
		|=> rd_data_r[6] == $past(filt_r[rsi_pkg::IX_C1_INV])
		&& rd_data_r[2] == $past(filt_r[rsi_pkg::IX_C0_INV]))
		else $error("buck output validity read wrong");

	conv0_curlim_a: assert property (
		(reg_rd_en && reg_addr == rsi_pkg::BUCK_STAT_ADDR)
		|=> rd_data_r[0] == $past(filt_r[rsi_pkg::IX_C0_ILIM]) && !rd_data_r[1])
		else $error("buck0 current limit read wrong");

	pg1_clear_a: assert property (
		(reg_wr_en && reg_addr == rsi_pkg::LIN_FLAGS_ADDR
		&& reg_wr_data[rsi_pkg::LIN1_PWRGD_BIT] && !set_vec[rsi_pkg::LIN1_PWRGD_BIT])
		|=> !flags_r[rsi_pkg::LIN1_PWRGD_BIT])
		else $error("lin1 power-good flag not cleared");

	short0_clear_a: assert property (
		(reg_wr_en && reg_addr == rsi_pkg::LIN_FLAGS_ADDR
		&& reg_wr_data[rsi_pkg::LIN0_SHORT_BIT] && !set_vec[rsi_pkg::LIN0_SHORT_BIT])
		|=> !flags_r[rsi_pkg::LIN0_SHORT_BIT])
		else $error("lin0 short flag not cleared");

	flag_rise_cause_a: assert property (
		(flags_r & ~$past(flags_r) & ~$past(set_vec)) == 8'h00)
		else $error("flag set without an event");

	rd_hold_a: assert property (
		!reg_rd_en |=> $stable(rd_data_r))
		else $error("read data changed without a read");
endmodule : rsi_regs
`default_nettype wire

// [verification/rsi_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module rsi_host_model (
	// clock
	input  wire logic       clk_sys,
	// register port
	output logic      [7:0] reg_addr,
	output logic            reg_wr_en,
	output logic      [7:0] reg_wr_data,
	output logic            reg_rd_en,
	input  wire logic [7:0] reg_rd_data
);
	initial begin
		reg_addr    = 8'h00;
		reg_wr_en   = 1'b0;
		reg_wr_data = 8'h00;
		reg_rd_en   = 1'b0;
	end

	// one strobe cycle; address and data are scrambled after it so a stale value never helps
	// read data is registered, so it is taken just after the strobe edge
	task automatic access(input logic [7:0] addr, input logic wr, input logic [7:0] data,
		output logic [7:0] rdata);
		@(posedge clk_sys);
		#1;
		reg_addr    = addr;
		reg_wr_data = data;
		reg_wr_en   = wr;
		reg_rd_en   = ~wr;
		@(posedge clk_sys);
		#1;
		reg_wr_en   = 1'b0;
		reg_rd_en   = 1'b0;
		reg_addr    = ~addr;
		reg_wr_data = ~data;
		rdata       = reg_rd_data;
	endtask : access
endmodule : rsi_host_model
`default_nettype wire

// [verification/rsi_regs_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module rsi_regs_tb;
	localparam int SC    = 20;
	localparam int LIMIT = 20000;
	logic        clk_sys   = 1'b0;
	logic        rst       = 1'b1;
	logic [16:0] mon       = '0;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wr_data;
	logic [7:0]  reg_rd_data;
	logic        reg_wr_en;
	logic        reg_rd_en;
	logic        linear_pending_summary;
	logic [7:0]  v;
	int          errors    = 0;
	int          tests_run = 0;
	int          cycles    = 0;

	always #12.5 clk_sys = ~clk_sys;

	// mon bits follow the package's raw condition index order
	rsi_regs #(.SC_CYCLES(SC)) dut_u (
		.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
		.reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
		.lin1_pg_fault(mon[0]), .lin0_pg_fault(mon[1]),
		.lin1_below_sc(mon[2]), .lin0_below_sc(mon[3]),
		.lin1_curlimit(mon[4]), .lin0_curlimit(mon[5]),
		.power_good_pin(mon[6]), .ext_clock_invalid(mon[7]),
		.thermal_shutdown_cmp(mon[8]), .thermal_warning_cmp(mon[9]),
		.input_overvoltage_cmp(mon[10]), .conv1_enabled(mon[11]),
		.conv0_enabled(mon[12]), .conv1_output_invalid(mon[13]),
		.conv0_output_invalid(mon[14]), .conv1_curlimit(mon[15]),
		.conv0_curlimit(mon[16]), .linear_pending_summary(linear_pending_summary)
	);

	rsi_host_model host_u (
		.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data)
	);

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wt

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] unused_rd;
		host_u.access(a, 1'b1, d, unused_rd);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		host_u.access(a, 1'b0, 8'h00, v);
	endtask : rd

	task automatic t_reset;
		rd(8'h1c);
		check("flags", 8'h00, v);
		rd(8'h1d);
		check("top", 8'h00, v);
		rd(8'h1e);
		check("buck", 8'h00, v);
		check("summary", 8'h00, {7'h00, linear_pending_summary});
		$display("test reset done");
	endtask : t_reset

	task automatic t_status;
		int ix [11] = '{6, 7, 8, 9, 10, 11, 13, 15, 12, 14, 16};
		int bt [11] = '{7, 4, 3, 2, 1, 7, 6, 4, 3, 2, 0};
		logic [7:0] a;
		for (int i = 0; i < 11; i++) begin
			a = (i < 5) ? 8'h1d : 8'h1e;
			mon[ix[i]] = 1'b1;
			wt(8);
			rd(a);
			check("status set", 8'h01 << bt[i], v);
			wr(a, 8'hff);
			rd(a);
			check("status read only", 8'h01 << bt[i], v);
			rd(8'h1c);
			check("no flag", 8'h00, v);
			mon[ix[i]] = 1'b0;
			wt(8);
			rd(a);
			check("status clear", 8'h00, v);
		end
		$display("test status done");
	endtask : t_status

	task automatic t_flags;
		int ix [4] = '{5, 4, 1, 0};
		int bt [4] = '{0, 4, 2, 6};
		logic [7:0] m;
		for (int i = 0; i < 4; i++) begin
			m = 8'h01 << bt[i];
			mon[ix[i]] = 1'b1;
			wt(4);
			mon[ix[i]] = 1'b0;
			wt(8);
			rd(8'h1c);
			check("flag set", m, v);
			check("summary set", 8'h01, {7'h00, linear_pending_summary});
			rd(8'h1f);
			check("unmapped", 8'h00, v);
			wr(8'h1c, ~m);
			rd(8'h1c);
			check("flag kept", m, v);
			wr(8'h1c, m);
			rd(8'h1c);
			check("flag cleared", 8'h00, v);
			check("summary clear", 8'h00, {7'h00, linear_pending_summary});
		end
		$display("test flags done");
	endtask : t_flags

	task automatic t_short;
		int ix [2] = '{3, 2};
		int bt [2] = '{1, 5};
		for (int i = 0; i < 2; i++) begin
			mon[ix[i]] = 1'b1;
			wt(SC - 4);
			mon[ix[i]] = 1'b0;
			wt(8);
			rd(8'h1c);
			check("short brief", 8'h00, v);
			mon[ix[i]] = 1'b1;
			wt(SC + 8);
			rd(8'h1c);
			check("short held", 8'h01 << bt[i], v);
			mon[ix[i]] = 1'b0;
			wr(8'h1c, 8'h01 << bt[i]);
			rd(8'h1c);
			check("short cleared", 8'h00, v);
		end
		$display("test short done");
	endtask : t_short

	// a still-present limit must re-arm its flag right after the clear
	task automatic t_rearm;
		mon[5] = 1'b1;
		wt(8);
		wr(8'h1c, 8'h01);
		rd(8'h1c);
		check("flag rearmed", 8'h01, v);
		mon[0] = 1'b1;
		wt(8);
		mon[5] = 1'b0;
		wt(8);
		wr(8'h1c, 8'h01);
		rd(8'h1c);
		check("other flag", 8'h40, v);
		check("summary held", 8'h01, {7'h00, linear_pending_summary});
		mon[0] = 1'b0;
		mon[4] = 1'b1;
		wt(8);
		mon[4] = 1'b0;
		wt(8);
		rst = 1'b1;
		wt(2);
		rst = 1'b0;
		rd(8'h1c);
		check("flags after reset", 8'h00, v);
		check("summary after reset", 8'h00, {7'h00, linear_pending_summary});
		$display("test rearm done");
	endtask : t_rearm

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			report_and_stop();
		end
	end

	initial begin
		wt(2);
		rst = 1'b0;
		t_reset();
		t_status();
		t_flags();
		t_short();
		t_rearm();
		report_and_stop();
	end
endmodule : rsi_regs_tb
`default_nettype wire
